/* hdl/key_builder_params.svh */
// Purpose: register offsets, field positions and reset values of the key field builder
// Assumes: 32-bit APB data, one register per aligned word, 8-bit byte address
// Notes:   definitions only
`ifndef KEY_BUILDER_PARAMS_SVH
`define KEY_BUILDER_PARAMS_SVH

`define ADDR_W            8
`define REG_CTRL          8'h00
`define REG_PORT          8'h04
`define REG_STATUS        8'h08
`define REG_RNG_BASE      8'h10
`define RNG_STRIDE        8'h08
`define RNG_BOUNDS_OFS    8'h04

// control register fields
`define CTRL_USE_CL_DSCP  0
`define CTRL_GIDX_SEL_LO  1
`define CTRL_TYPE1_LO     3
`define CTRL_TYPE2_LO     5
`define CTRL_RESET        7'h00
`define PORT_RESET        6'h00

// status register fields
`define STAT_COUNT_W      16
`define STAT_TYPE_LO      16

// fixed distance from IPv4 header start to its payload, options ignored
`define IP4_HDR_BYTES     20

`endif

/* hdl/key_builder_pkg.sv */
// Purpose: shared types of the key field builder
// Assumes: constants live in key_builder_params.svh
// Notes:   binary codes written out
package key_builder_pkg;

  typedef enum logic [1:0] {
    KEY_LL_FULL       = 2'b00,
    KEY_NORMAL        = 2'b01,
    KEY_NORMAL_5TUPLE = 2'b10,
    KEY_CUSTOM_2      = 2'b11
  } wide_key_type_e;

  typedef enum logic [2:0] {
    RNG_SPORT    = 3'b000,
    RNG_DPORT    = 3'b001,
    RNG_EITHER   = 3'b010,
    RNG_VID      = 3'b011,
    RNG_DSCP     = 3'b100,
    RNG_CUSTOM   = 3'b101,
    RNG_OFF_A    = 3'b110,
    RNG_OFF_B    = 3'b111
  } range_kind_e;

  typedef enum logic [1:0] {
    GIDX_DEF_ZERO  = 2'b00,
    GIDX_DEF_LPORT = 2'b01,
    GIDX_DEF_MASQ  = 2'b10,
    GIDX_DEF_RSVD  = 2'b11
  } gidx_default_e;

  typedef enum logic [1:0] {
    NXT_KEEP_DEFAULT = 2'b00,
    NXT_REPLACE      = 2'b01,
    NXT_ADD          = 2'b10,
    NXT_OR           = 2'b11
  } next_index_ctrl_e;

endpackage

/* hdl/frame_view_if.sv */
// Purpose: carries the parsed frame bytes to the payload pickers
// Assumes: byte 0 of the frame sits in bits 7:0
// Notes:   none
`timescale 1ns/1ps
`default_nettype none
interface frame_view_if #(
  parameter int FRAME_BYTES = 128
);
  logic [FRAME_BYTES*8-1:0] bytes;
  modport src  (output bytes);
  modport sink (input  bytes);
endinterface
`default_nettype wire

/* hdl/payload_byte_picker.sv */
// Purpose: picks OUT_BYTES consecutive frame bytes from a start position
// Assumes: start position in bytes from frame start
// Notes:   first byte lands in the most significant lane; bytes past the frame read zero
`timescale 1ns/1ps
`default_nettype none
module payload_byte_picker #(
  parameter int FRAME_BYTES = 128,
  parameter int POS_W       = 7,
  parameter int OUT_BYTES   = 4
) (
  frame_view_if.sink                 fv,
  input  wire logic [POS_W-1:0]      start_pos,
  output logic [OUT_BYTES*8-1:0]     picked
);
  localparam int IW = POS_W + $clog2(OUT_BYTES + 1);

  for (genvar k = 0; k < OUT_BYTES; k++) begin : g_byte
    logic [IW-1:0] idx;
    assign idx = IW'(start_pos) + IW'(k);
    assign picked[(OUT_BYTES-k)*8-1 -: 8] = (idx < IW'(FRAME_BYTES)) ? fv.bytes[idx*8 +: 8] : 8'h00;
  end
endmodule
`default_nettype wire

/* hdl/range_checker_bank.sv */
// Purpose: bank of range checkers producing the range mask
// Assumes: values from the frame, dscp already remapped by basic classification
// Notes:   an inclusive window low..high; unused kinds never hit
`timescale 1ns/1ps
`default_nettype none
module range_checker_bank
  import key_builder_pkg::*;
#(
  parameter int NUM = 8
) (
  input  wire logic [NUM*3-1:0]  kinds,
  input  wire logic [NUM*32-1:0] bounds,
  input  wire logic [15:0]       sport,
  input  wire logic [15:0]       dport,
  input  wire logic [11:0]       vid,
  input  wire logic [5:0]        dscp,
  input  wire logic [15:0]       custom_value,
  output logic [NUM-1:0]         hits
);
  function automatic logic in_win(input logic [15:0] v, input logic [31:0] b);
    in_win = (v >= b[15:0]) && (v <= b[31:16]);
  endfunction

  for (genvar i = 0; i < NUM; i++) begin : g_chk
    range_kind_e   kind;
    logic [31:0]   bnd;
    assign kind = range_kind_e'(kinds[i*3 +: 3]);
    assign bnd  = bounds[i*32 +: 32];
    always_comb begin
      case (kind)
        RNG_SPORT:  hits[i] = in_win(sport, bnd);
        RNG_DPORT:  hits[i] = in_win(dport, bnd);
        RNG_EITHER: hits[i] = in_win(sport, bnd) || in_win(dport, bnd);
        RNG_VID:    hits[i] = in_win({4'h0, vid}, bnd);
        RNG_DSCP:   hits[i] = in_win({10'h000, dscp}, bnd);
        RNG_CUSTOM: hits[i] = in_win(custom_value, bnd);
        default:    hits[i] = 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

/* hdl/key_field_builder.sv */
// Purpose: builds four-slot trailing fields and eight-slot leading fields of classifier keys
// Assumes: parser and previous lookup action on pclk; APB slave for configuration
// Notes:   fields are assembled combinationally and presented one clock after frm_valid
//
// What this block does
// - dscp field carries frame dscp, or classified dscp when the option is set
// - destination field carries IPv4 address or IPv6 address bits 31:0
// - LLC frames put control byte then payload bytes 0..2 in source field
// - SNAP frames put protocol id bytes 2..0 then payload byte 0
// - IP frames put IPv4 source or IPv6 source bits 31:0
// - other frames put payload bytes 0..3 in source field
// - protocol field is IPv4 protocol or IPv6 next header
// - range mask from checkers on ports, vid, remapped dscp or custom value
// - IP payload word taken 20 bytes after IPv4 header start
// - custom field holds 15 bytes from the current frame pointer
// - for Ethernet frames custom bytes start after the Ethernet layer
// - wide key opens with a 2-bit type code 0..3
// - pass flag set for first lookup, cleared for second
// - ingress port field carries the configured logical port number in type 0 keys, zero in other key types
// - service flag set when previous action chose service index as index, except in type 0 keys where it stays clear
// - generic index from previous next-index control and value, selectable default; zero in type 0 keys
// - untagged frames give outer vlan id zero
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`include "key_builder_params.svh"
`timescale 1ns/1ps
`default_nettype none
module key_field_builder #(
  parameter int FRAME_BYTES = 128,
  parameter int POS_W       = 7,
  parameter int NUM_RNG     = 8
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic [7:0]                    paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   pwdata,
  output logic [31:0]                        prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          frm_valid,
  input  wire logic                          lookup_first,
  input  wire logic                          length_type_flag,
  input  wire logic                          snap_or_ip_flag,
  input  wire logic                          ipv4_flag,
  input  wire logic                          frame_is_eth,
  input  wire logic                          frm_tagged,
  input  wire logic [11:0]                   frm_vid,
  input  wire logic [5:0]                    frm_dscp,
  input  wire logic [5:0]                    classified_dscp,
  input  wire logic [5:0]                    remapped_dscp,
  input  wire logic [31:0]                   ip4_dip,
  input  wire logic [31:0]                   ip6_dip_low,
  input  wire logic [31:0]                   ip4_sip,
  input  wire logic [31:0]                   ip6_sip_low,
  input  wire logic [7:0]                    ip4_protocol,
  input  wire logic [7:0]                    ip6_next_header,
  input  wire logic [7:0]                    llc_ctrl,
  input  wire logic [23:0]                   snap_pid,
  input  wire logic [15:0]                   l4_sport,
  input  wire logic [15:0]                   l4_dport,
  input  wire logic [15:0]                   range_custom_value,
  input  wire logic [FRAME_BYTES*8-1:0]      frame_bytes,
  input  wire logic [POS_W-1:0]              payload_pos,
  input  wire logic [POS_W-1:0]              l3_pos,
  input  wire logic [POS_W-1:0]              eth_end_pos,
  input  wire logic [POS_W-1:0]              frame_pointer,
  input  wire logic [5:0]                    masq_port,
  input  wire logic                          prev_svc_as_gidx,
  input  wire key_builder_pkg::next_index_ctrl_e next_index_control,
  input  wire logic [11:0]                   next_index_value,
  input  wire logic [11:0]                   service_index,
  output logic                               key_valid,
  output logic [5:0]                         dscp_key_field,
  output logic [31:0]                        dest_ip_key_field,
  output logic [31:0]                        source_ip_overloaded_field,
  output logic [7:0]                         ip_protocol_field,
  output logic [NUM_RNG-1:0]                 range_check_mask,
  output logic [31:0]                        ip_payload_word,
  output logic [119:0]                       custom_payload_bytes,
  output key_builder_pkg::wide_key_type_e    wide_key_type,
  output logic                               lookup_first_flag,
  output logic [5:0]                         logical_ingress_port,
  output logic                               generic_index_service_flag,
  output logic [11:0]                        generic_index,
  output logic [11:0]                        outer_vlan_id_field
);
  import key_builder_pkg::*;

  // configuration and status state
  logic                        use_classified_dscp_enable_r;
  gidx_default_e               generic_index_default_select_r;
  wide_key_type_e              type_first_r;
  wide_key_type_e              type_second_r;
  logic [5:0]                  logical_port_number_r;
  logic [NUM_RNG*3-1:0]        rng_kind_r;
  logic [NUM_RNG*32-1:0]       rng_bounds_r;
  logic [`STAT_COUNT_W-1:0]    key_count_r;

  // APB access decode
  logic        wr_go;
  logic        setup;
  logic        is_rng;
  logic [7:0]  rng_ofs;
  logic [2:0]  rng_idx;
  logic        rng_bounds_sel;
  logic        addr_ok;
  logic [31:0] rd_nxt;

  assign setup          = psel && !penable;
  assign wr_go          = psel && penable && pready && pwrite;
  assign rng_ofs        = paddr - `REG_RNG_BASE;
  assign is_rng         = (paddr >= `REG_RNG_BASE) && (rng_ofs < 8'(NUM_RNG * 8)) && (paddr[1:0] == 2'b00);
  assign rng_idx        = rng_ofs[5:3];
  assign rng_bounds_sel = rng_ofs[2];
  assign addr_ok        = is_rng || (paddr == `REG_CTRL) || (paddr == `REG_PORT) || (paddr == `REG_STATUS);

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (paddr == `REG_CTRL) begin
      rd_nxt[`CTRL_USE_CL_DSCP]       = use_classified_dscp_enable_r;
      rd_nxt[`CTRL_GIDX_SEL_LO +: 2]  = generic_index_default_select_r;
      rd_nxt[`CTRL_TYPE1_LO +: 2]     = type_first_r;
      rd_nxt[`CTRL_TYPE2_LO +: 2]     = type_second_r;
    end else if (paddr == `REG_PORT) begin
      rd_nxt[5:0] = logical_port_number_r;
    end else if (paddr == `REG_STATUS) begin
      rd_nxt[`STAT_COUNT_W-1:0]     = key_count_r;
      rd_nxt[`STAT_TYPE_LO +: 2]    = wide_key_type;
    end else if (is_rng) begin
      if (rng_bounds_sel) begin
        rd_nxt = rng_bounds_r[rng_idx*32 +: 32];
      end else begin
        rd_nxt[2:0] = rng_kind_r[rng_idx*3 +: 3];
      end
    end
  end

  // answer one cycle into the access phase: pready, prdata and pslverr from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
      pslverr <= !addr_ok;
    end else begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      use_classified_dscp_enable_r   <= 1'b0;
      generic_index_default_select_r <= GIDX_DEF_ZERO;
      type_first_r                   <= KEY_LL_FULL;
      type_second_r                  <= KEY_LL_FULL;
    end else if (wr_go && paddr == `REG_CTRL) begin
      use_classified_dscp_enable_r   <= pwdata[`CTRL_USE_CL_DSCP];
      generic_index_default_select_r <= gidx_default_e'(pwdata[`CTRL_GIDX_SEL_LO +: 2]);
      type_first_r                   <= wide_key_type_e'(pwdata[`CTRL_TYPE1_LO +: 2]);
      type_second_r                  <= wide_key_type_e'(pwdata[`CTRL_TYPE2_LO +: 2]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      logical_port_number_r <= `PORT_RESET;
    end else if (wr_go && paddr == `REG_PORT) begin
      logical_port_number_r <= pwdata[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rng_kind_r   <= '1;
      rng_bounds_r <= '0;
    end else if (wr_go && is_rng) begin
      if (rng_bounds_sel) begin
        rng_bounds_r[rng_idx*32 +: 32] <= pwdata;
      end else begin
        rng_kind_r[rng_idx*3 +: 3] <= pwdata[2:0];
      end
    end
  end

  // payload pickers on the frame bytes
  frame_view_if #(.FRAME_BYTES(FRAME_BYTES)) fv ();
  assign fv.bytes = frame_bytes;

  logic [POS_W-1:0] ip_payload_pos;
  logic [POS_W-1:0] custom_pos;
  logic [31:0]      payload_word;
  logic [31:0]      ip_payload_nxt;
  logic [119:0]     custom_nxt;

  assign ip_payload_pos = POS_W'(l3_pos + POS_W'(`IP4_HDR_BYTES));
  assign custom_pos     = frame_is_eth ? POS_W'(eth_end_pos + frame_pointer) : frame_pointer;

  payload_byte_picker #(.FRAME_BYTES(FRAME_BYTES), .POS_W(POS_W), .OUT_BYTES(4)) u_pick_payload (
    .fv        (fv),
    .start_pos (payload_pos),
    .picked    (payload_word)
  );

  payload_byte_picker #(.FRAME_BYTES(FRAME_BYTES), .POS_W(POS_W), .OUT_BYTES(4)) u_pick_ip_payload (
    .fv        (fv),
    .start_pos (ip_payload_pos),
    .picked    (ip_payload_nxt)
  );

  payload_byte_picker #(.FRAME_BYTES(FRAME_BYTES), .POS_W(POS_W), .OUT_BYTES(15)) u_pick_custom (
    .fv        (fv),
    .start_pos (custom_pos),
    .picked    (custom_nxt)
  );

  logic [NUM_RNG-1:0] range_nxt;

  range_checker_bank #(.NUM(NUM_RNG)) u_ranges (
    .kinds        (rng_kind_r),
    .bounds       (rng_bounds_r),
    .sport        (l4_sport),
    .dport        (l4_dport),
    .vid          (frm_vid),
    .dscp         (remapped_dscp),
    .custom_value (range_custom_value),
    .hits         (range_nxt)
  );

  // four-slot trailing fields
  logic [5:0]  dscp_nxt;
  logic [31:0] dip_nxt;
  logic [31:0] sip_nxt;
  logic [7:0]  proto_nxt;

  assign dscp_nxt  = use_classified_dscp_enable_r ? classified_dscp : frm_dscp;
  assign dip_nxt   = ipv4_flag ? ip4_dip : ip6_dip_low;
  assign proto_nxt = ipv4_flag ? ip4_protocol : ip6_next_header;

  always_comb begin
    case ({length_type_flag, snap_or_ip_flag})
      2'b00:   sip_nxt = {llc_ctrl, payload_word[31:8]};
      2'b01:   sip_nxt = {snap_pid, payload_word[31:24]};
      2'b11:   sip_nxt = ipv4_flag ? ip4_sip : ip6_sip_low;
      2'b10:   sip_nxt = payload_word;
      default: sip_nxt = 32'h0000_0000;
    endcase
  end

  // eight-slot leading fields
  wide_key_type_e type_nxt;
  logic [11:0]    gidx_default;
  logic [11:0]    gidx_nxt;
  logic           has_port;

  assign type_nxt = lookup_first ? type_first_r : type_second_r;
  assign has_port = (type_nxt == KEY_LL_FULL);

  always_comb begin
    case (generic_index_default_select_r)
      GIDX_DEF_ZERO:  gidx_default = 12'h000;
      GIDX_DEF_LPORT: gidx_default = {6'h00, logical_port_number_r};
      GIDX_DEF_MASQ:  gidx_default = {6'h00, masq_port};
      default:        gidx_default = 12'h000;
    endcase
  end

  always_comb begin
    if (prev_svc_as_gidx) begin
      gidx_nxt = service_index;
    end else begin
      case (next_index_control)
        NXT_KEEP_DEFAULT: gidx_nxt = gidx_default;
        NXT_REPLACE:      gidx_nxt = next_index_value;
        NXT_ADD:          gidx_nxt = 12'(gidx_default + next_index_value);
        NXT_OR:           gidx_nxt = gidx_default | next_index_value;
        default:          gidx_nxt = gidx_default;
      endcase
    end
  end

  // presentation registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_valid <= 1'b0;
    end else begin
      key_valid <= frm_valid;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dscp_key_field             <= 6'h00;
      dest_ip_key_field          <= 32'h0000_0000;
      source_ip_overloaded_field <= 32'h0000_0000;
      ip_protocol_field          <= 8'h00;
      range_check_mask           <= '0;
      ip_payload_word            <= 32'h0000_0000;
      custom_payload_bytes       <= '0;
    end else if (frm_valid) begin
      dscp_key_field             <= dscp_nxt;
      dest_ip_key_field          <= dip_nxt;
      source_ip_overloaded_field <= sip_nxt;
      ip_protocol_field          <= proto_nxt;
      range_check_mask           <= range_nxt;
      ip_payload_word            <= ip_payload_nxt;
      custom_payload_bytes       <= custom_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wide_key_type              <= KEY_LL_FULL;
      lookup_first_flag          <= 1'b0;
      logical_ingress_port       <= 6'h00;
      generic_index_service_flag <= 1'b0;
      generic_index              <= 12'h000;
      outer_vlan_id_field        <= 12'h000;
    end else if (frm_valid) begin
      wide_key_type              <= type_nxt;
      lookup_first_flag          <= lookup_first;
      logical_ingress_port       <= has_port ? logical_port_number_r : 6'h00;
      generic_index_service_flag <= has_port ? 1'b0 : prev_svc_as_gidx;
      generic_index              <= has_port ? 12'h000 : gidx_nxt;
      outer_vlan_id_field        <= frm_tagged ? frm_vid : 12'h000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_count_r <= '0;
    end else if (frm_valid) begin
      key_count_r <= key_count_r + 1'b1;
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_dscp_source: assert property (frm_valid |=> dscp_key_field ==
    ($past(use_classified_dscp_enable_r) ? $past(classified_dscp) : $past(frm_dscp)))
    else $error("dscp key field from wrong source");
  a_dip_select: assert property (frm_valid && !ipv4_flag |=> dest_ip_key_field == $past(ip6_dip_low))
    else $error("destination field not ipv6 low word");
  a_sip_llc: assert property (frm_valid && !length_type_flag && !snap_or_ip_flag
    |=> source_ip_overloaded_field[31:24] == $past(llc_ctrl))
    else $error("llc source field lacks control byte");
  a_sip_snap: assert property (frm_valid && !length_type_flag && snap_or_ip_flag
    |=> source_ip_overloaded_field[31:8] == $past(snap_pid))
    else $error("snap source field lacks protocol id");
  a_sip_ipv4: assert property (frm_valid && length_type_flag && snap_or_ip_flag && ipv4_flag
    |=> source_ip_overloaded_field == $past(ip4_sip))
    else $error("ipv4 source address missing");
  a_sip_other: assert property (frm_valid && length_type_flag && !snap_or_ip_flag
    |=> source_ip_overloaded_field == $past(payload_word))
    else $error("other frame source field not payload");
  a_proto_pick: assert property (frm_valid |=> ip_protocol_field ==
    ($past(ipv4_flag) ? $past(ip4_protocol) : $past(ip6_next_header)))
    else $error("protocol field wrong");
  a_pass_flag: assert property (frm_valid |=> lookup_first_flag == $past(lookup_first))
    else $error("lookup pass flag wrong");
  a_port_field: assert property (frm_valid && type_nxt == KEY_LL_FULL
    |=> logical_ingress_port == $past(logical_port_number_r) && generic_index == 12'h000)
    else $error("ingress port field wrong");
  a_svc_index: assert property (frm_valid && prev_svc_as_gidx && type_nxt != KEY_LL_FULL
    |=> generic_index_service_flag && generic_index == $past(service_index))
    else $error("service index not used");
  a_vid_untagged: assert property (frm_valid && !frm_tagged |=> outer_vlan_id_field == 12'h000)
    else $error("untagged frame vid not zero");
  a_key_hold: assert property (!frm_valid |=> $stable(wide_key_type) && !key_valid)
    else $error("key changed without frame");
  a_apb_answer: assert property (setup |=> !pready ##1 pready)
    else $error("apb answer timing wrong");

  c_llc_key:    cover property (frm_valid && !length_type_flag && !snap_or_ip_flag);
  c_ipv6_key:   cover property (frm_valid && length_type_flag && snap_or_ip_flag && !ipv4_flag);
  c_service:    cover property (frm_valid && prev_svc_as_gidx && !has_port);
  c_range_hit:  cover property (frm_valid && |range_nxt);
endmodule
`default_nettype wire

/* verif/frame_parser_model.sv */
// Purpose: parser stand-in giving frame bytes and byte positions
// Assumes: positions stay clear of the frame end
// Notes: a new frame at each edge with refresh high
`timescale 1ns/1ps
`default_nettype none
module frame_parser_model (
  input  wire logic     pclk,
  input  wire logic     refresh,
  output logic [1023:0] frame_bytes = '0,
  output logic [6:0]    payload_pos = '0,
  output logic [6:0]    l3_pos = '0,
  output logic [6:0]    eth_end_pos = '0,
  output logic [6:0]    frame_pointer = '0
);
  always @(posedge pclk) begin
    if (refresh) begin
      for (int k = 0; k < 32; k++) frame_bytes[32*k+:32] <= $urandom;
      payload_pos <= 7'($urandom % 100);
      l3_pos <= 7'($urandom % 60);
      eth_end_pos <= 7'($urandom % 30);
      frame_pointer <= 7'($urandom % 40);
    end
  end
endmodule
`default_nettype wire

/* verif/testbench.sv */
// Purpose: self-checking bench of the key field builder
// Assumes: APB with one wait state, key one clock after frm_valid
// Notes: seeded random frames with boundary ports among them
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import key_builder_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, frm_valid = 0, refresh = 0, lookup_first = 0;
  logic length_type_flag = 0, snap_or_ip_flag = 0, ipv4_flag = 0, frame_is_eth = 0, frm_tagged = 0;
  logic prev_svc_as_gidx = 0, pready, pslverr, key_valid, lookup_first_flag, generic_index_service_flag, er;
  logic [7:0] paddr = 0, ip4_protocol = 0, ip6_next_header = 0, llc_ctrl = 0, range_check_mask, ip_protocol_field;
  logic [31:0] pwdata = 0, ip4_dip = 0, ip6_dip_low = 0, ip4_sip = 0, ip6_sip_low = 0, rd;
  logic [31:0] prdata, dest_ip_key_field, source_ip_overloaded_field, ip_payload_word;
  logic [5:0] frm_dscp = 0, classified_dscp = 0, remapped_dscp = 0, masq_port = 0, lp = 0, dscp_key_field, logical_ingress_port;
  logic [11:0] frm_vid = 0, next_index_value = 0, service_index = 0, generic_index, outer_vlan_id_field;
  logic [15:0] l4_sport = 0, l4_dport = 0, range_custom_value = 0, nkeys = 0;
  logic [23:0] snap_pid = 0;
  logic [1023:0] frame_bytes;
  logic [6:0] payload_pos, l3_pos, eth_end_pos, frame_pointer, ctrl;
  logic [119:0] custom_payload_bytes;
  logic [1:0] t;
  next_index_ctrl_e next_index_control = NXT_KEEP_DEFAULT;
  wide_key_type_e wide_key_type;
  int err_total = 0, checked = 0;
  always #5 pclk = ~pclk;
  frame_parser_model frame_parser_model_i (.pclk, .refresh, .frame_bytes, .payload_pos, .l3_pos, .eth_end_pos,
    .frame_pointer);
  key_field_builder key_field_builder_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .frm_valid, .lookup_first, .length_type_flag, .snap_or_ip_flag, .ipv4_flag, .frame_is_eth,
    .frm_tagged, .frm_vid, .frm_dscp, .classified_dscp, .remapped_dscp, .ip4_dip, .ip6_dip_low, .ip4_sip,
    .ip6_sip_low, .ip4_protocol, .ip6_next_header, .llc_ctrl, .snap_pid, .l4_sport, .l4_dport, .range_custom_value,
    .frame_bytes, .payload_pos, .l3_pos, .eth_end_pos, .frame_pointer, .masq_port, .prev_svc_as_gidx,
    .next_index_control, .next_index_value, .service_index, .key_valid, .dscp_key_field, .dest_ip_key_field,
    .source_ip_overloaded_field, .ip_protocol_field, .range_check_mask, .ip_payload_word, .custom_payload_bytes,
    .wide_key_type, .lookup_first_flag, .logical_ingress_port, .generic_index_service_flag, .generic_index,
    .outer_vlan_id_field);
  task summarize;
    if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [119:0] g, input logic [119:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1) break;
    end
    if (n == 20) err_total++;
    if (n == 20) summarize;
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  function logic [119:0] pk(input int p, input int n);
    pk = 0;
    for (int k = 0; k < n; k++) pk = {pk[111:0], frame_bytes[8*(p+k)+:8]};
  endfunction
  function logic [31:0] sip;
    case ({length_type_flag, snap_or_ip_flag})
      2'b00: sip = {llc_ctrl, 24'h0} | 32'(pk(payload_pos, 3));
      2'b01: sip = {snap_pid, 8'h00} | 32'(pk(payload_pos, 1));
      2'b11: sip = ipv4_flag ? ip4_sip : ip6_sip_low;
      default: sip = 32'(pk(payload_pos, 4));
    endcase
  endfunction
  function logic [11:0] gx;
    logic [11:0] d;
    d = ctrl[2:1] == 1 ? 12'(lp) : 12'h000;
    if (ctrl[2:1] == 2) d = 12'(masq_port);
    case (next_index_control)
      NXT_KEEP_DEFAULT: gx = d;
      NXT_REPLACE: gx = next_index_value;
      NXT_ADD: gx = d + next_index_value;
      default: gx = d | next_index_value;
    endcase
    if (prev_svc_as_gidx) gx = service_index;
    if (t == 0) gx = 0;
  endfunction
  task key;
    int n;
    @(posedge pclk);
    refresh <= 1;
    {lookup_first, length_type_flag, snap_or_ip_flag, ipv4_flag, frame_is_eth, frm_tagged} <= 6'($urandom);
    {prev_svc_as_gidx, frm_vid, frm_dscp, classified_dscp, remapped_dscp, masq_port} <= 37'({$urandom, $urandom});
    {ip4_dip, ip6_dip_low, ip4_sip, ip6_sip_low} <= {$urandom, $urandom, $urandom, $urandom};
    {ip4_protocol, ip6_next_header, llc_ctrl, snap_pid, next_index_value, service_index} <= 72'({$urandom, $urandom, $urandom});
    l4_sport <= ($urandom % 3 == 0) ? 16'h1000 : 16'($urandom);
    next_index_control <= next_index_ctrl_e'($urandom % 4);
    @(posedge pclk);
    {refresh, frm_valid} <= 2'b01;
    @(posedge pclk);
    frm_valid <= 0;
    nkeys++;
    for (n = 0; key_valid !== 1; n++) begin
      if (n > 4) err_total++;
      if (n > 4) summarize;
      @(negedge pclk);
    end
    t = lookup_first ? ctrl[4:3] : ctrl[6:5];
    chk(wide_key_type, t);
    chk(lookup_first_flag, lookup_first);
    chk(dscp_key_field, ctrl[0] ? classified_dscp : frm_dscp);
    chk(dest_ip_key_field, ipv4_flag ? ip4_dip : ip6_dip_low);
    chk(source_ip_overloaded_field, sip());
    chk(ip_protocol_field, ipv4_flag ? ip4_protocol : ip6_next_header);
    chk(range_check_mask, {remapped_dscp inside {[10:40]}, l4_sport inside {[16'h1000:16'h8000]}});
    chk(ip_payload_word, pk(l3_pos + 20, 4));
    chk(custom_payload_bytes, pk(frame_is_eth ? eth_end_pos + frame_pointer : frame_pointer, 15));
    chk(logical_ingress_port, t == 0 ? lp : 6'h00);
    chk(generic_index_service_flag, t != 0 && prev_svc_as_gidx);
    chk(generic_index, gx());
    chk(outer_vlan_id_field, frm_tagged ? frm_vid : 12'h000);
  endtask
  initial begin
    void'($urandom(127));
    repeat (10) @(posedge pclk);
    presetn <= 1;
    apb(0, 8'h04, 0);
    chk(rd, 0);
    apb(0, 8'hFC, 0);
    chk({er, rd}, 33'h100000000);
    apb(1, 8'h10, 0);
    apb(1, 8'h14, 32'h80001000);
    apb(1, 8'h18, 4);
    apb(1, 8'h1C, 32'h0028000A);
    for (int i = 0; i < 150; i++) begin
      ctrl = 7'($urandom);
      apb(1, 8'h00, 32'(ctrl));
      apb(0, 8'h00, 0);
      chk(rd, 32'(ctrl));
      lp = 6'($urandom);
      apb(1, 8'h04, 32'(lp));
      apb(0, 8'h04, 0);
      chk(rd, 32'(lp));
      key;
    end
    apb(0, 8'h08, 0);
    chk(rd[15:0], nkeys);
    summarize;
  end
endmodule
`default_nettype wire
